/* File: hw/olfs_sequencer.v */
// Object list frame sequencer: header, then per-object frames by type.
// Assumes a frame sink that takes a frame on frame_valid and frame_ready.
//
// How it works
// - Object frames only for cycles that start while objects are selected.
// - One header 0x60A first in each list.
// - Header count equals frames per type.
// - One general frame 0x60B per object.
// - Quality frames 0x60C only when enabled.
// - Extended frames 0x60D only when enabled.
// - Warning frames 0x60E only with collision detection.
// - Order general, quality, extended, warning.
// - Count at bit 0, 8 bits, max 100.
// - 16-bit cycle counter at 16, wraps.
// - 4-bit format version at bit 28.
// - 8-bit stable track identifier at bit 0.
// - Distances packed with offsets, 0.2 m steps.
// - Longitudinal velocity 10 bits at 46.
// - Lateral velocity and cross section packed.
// - Stationary: lateral from yaw, longitudinal projected.
// - Moving: lateral zero, longitudinal over cosine.
// - Dynamic property 3 bits at 48.
// - Quality frame carries 3-bit measurement state.
`default_nettype none
`include "olfs_defs.vh"
module olfs_sequencer
(
    input wire mclk,
    input wire rst,
    input wire [1:0] output_type_select,
    input wire quality_frames_enable,
    input wire extended_frames_enable,
    input wire collision_detect_config,
    input wire cycle_start,
    input wire [7:0] list_count,
    input wire obj_wr,
    input wire [6:0] obj_wr_index,
    input wire [7:0] track_identifier,
    input wire signed [15:0] long_distance,
    input wire signed [15:0] lat_distance,
    input wire signed [15:0] radial_velocity,
    input wire signed [15:0] azimuth_sin,
    input wire signed [15:0] azimuth_cos,
    input wire signed [15:0] yaw_rate,
    input wire signed [15:0] rotation_lever,
    input wire obj_stationary,
    input wire [2:0] dynamic_property,
    input wire signed [15:0] cross_section,
    input wire [2:0] measurement_state,
    input wire frame_ready,
    output wire frame_valid,
    output wire [10:0] frame_ident,
    output wire [63:0] frame_data,
    output wire busy,
    output wire wr_refused
);
    // ************************************************************
    // Declarations
    // ************************************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_HDR = 3'd1;
    localparam ST_RD = 3'd2;
    localparam ST_LOAD = 3'd3;
    localparam ST_SEND = 3'd4;

    localparam PH_GEN = 3'd0;
    localparam PH_QUAL = 3'd1;
    localparam PH_EXT = 3'd2;
    localparam PH_WARN = 3'd3;
    localparam PH_DONE = 3'd4;

    reg [2:0] state_q;
    reg [2:0] phase_q;
    reg [6:0] idx_q;
    reg [7:0] count_q;
    reg [2:0] enables_q;
    reg [15:0] cycle_counter_q;
    reg frame_valid_q;
    reg [10:0] frame_ident_q;
    reg [63:0] frame_data_q;
    reg busy_q;
    reg wr_refused_q;

    reg p_wr_q;
    reg [6:0] p_idx_q;
    reg [7:0] p_id_q;
    reg signed [15:0] p_dlong_q;
    reg signed [15:0] p_dlat_q;
    reg [2:0] p_dyn_q;
    reg signed [15:0] p_rcs_q;
    reg [2:0] p_ms_q;

    wire signed [39:0] long_vel;
    wire signed [39:0] lat_vel;
    wire [66:0] rd_data;
    wire [63:0] gen_word;
    wire [7:0] object_count;
    wire wr_ok;
    wire [2:0] next_ph;

    // ************************************************************
    // Functions
    // ************************************************************
    // Places a field so that its least significant bit sits at start and
    // further bits climb within the byte, then continue in the byte before.
    function [63:0] put;
        input [63:0] w;
        input [15:0] v;
        input integer start;
        input integer len;
        integer i;
        integer p;
        reg [63:0] r;
        begin
            r = w;
            p = start;
            for (i = 0; i < 16; i = i + 1)
            begin
                if (i < len)
                begin
                    r[p] = v[i];
                    if (p % 8 == 7)
                        p = p - 15;
                    else
                        p = p + 1;
                end
            end
            put = r;
        end
    endfunction

    // Converts a physical value to a raw field value, saturating.
    function [15:0] cvt;
        input signed [39:0] x;
        input signed [39:0] ofs;
        input integer sh;
        input integer len;
        reg signed [39:0] t;
        reg signed [39:0] m;
        begin
            t = (x - ofs) >>> sh;
            m = (40'sd1 <<< len) - 40'sd1;
            if (t < 40'sd0)
                cvt = 16'h0000;
            else if (t > m)
                cvt = m[15:0];
            else
                cvt = t[15:0];
        end
    endfunction

    // Next enabled frame type after ph; bit 0 quality, 1 extended, 2 warning.
    function [2:0] next_phase;
        input [2:0] ph;
        input [2:0] en;
        begin
            if (ph < PH_QUAL && en[0])
                next_phase = PH_QUAL;
            else if (ph < PH_EXT && en[1])
                next_phase = PH_EXT;
            else if (ph < PH_WARN && en[2])
                next_phase = PH_WARN;
            else
                next_phase = PH_DONE;
        end
    endfunction

    // ************************************************************
    // Object record write path
    // ************************************************************
    olfs_vel_calc u_vel
    (
        .mclk(mclk),
        .rst(rst),
        .long_distance(long_distance),
        .radial_velocity(radial_velocity),
        .azimuth_sin(azimuth_sin),
        .azimuth_cos(azimuth_cos),
        .yaw_rate(yaw_rate),
        .rotation_lever(rotation_lever),
        .obj_stationary(obj_stationary),
        .long_vel(long_vel),
        .lat_vel(lat_vel)
    );

    // Slots are refused while a list is going out so that frames of one
    // cycle never mix old and new records.
    assign wr_ok = obj_wr && !busy_q && (obj_wr_index < `OLFS_MAX_OBJECTS);

    always @(posedge mclk)
    begin
        if (rst)
        begin
            p_wr_q <= 1'b0;
            p_idx_q <= 7'h00;
            p_id_q <= 8'h00;
            p_dlong_q <= 16'sh0000;
            p_dlat_q <= 16'sh0000;
            p_dyn_q <= 3'h0;
            p_rcs_q <= 16'sh0000;
            p_ms_q <= 3'h0;
            wr_refused_q <= 1'b0;
        end
        else
        begin
            p_wr_q <= wr_ok;
            p_idx_q <= obj_wr_index;
            p_id_q <= track_identifier;
            p_dlong_q <= long_distance;
            p_dlat_q <= lat_distance;
            p_dyn_q <= dynamic_property;
            p_rcs_q <= cross_section;
            p_ms_q <= measurement_state;
            wr_refused_q <= obj_wr && !wr_ok;
        end
    end

    assign gen_word =
        put(put(put(put(put(put(put(64'h0000000000000000,
        {8'h00, p_id_q}, `OLFS_TID_START, `OLFS_TID_LEN),
        cvt({{24{p_dlong_q[15]}}, p_dlong_q}, `OLFS_DLONG_OFS,
            `OLFS_DIST_SHIFT, `OLFS_DLONG_LEN),
        `OLFS_DLONG_START, `OLFS_DLONG_LEN),
        cvt({{24{p_dlat_q[15]}}, p_dlat_q}, `OLFS_DLAT_OFS,
            `OLFS_DIST_SHIFT, `OLFS_DLAT_LEN),
        `OLFS_DLAT_START, `OLFS_DLAT_LEN),
        cvt(long_vel, `OLFS_VLONG_OFS, `OLFS_VEL_SHIFT, `OLFS_VLONG_LEN),
        `OLFS_VLONG_START, `OLFS_VLONG_LEN),
        {13'h0000, p_dyn_q}, `OLFS_DYN_START, `OLFS_DYN_LEN),
        cvt(lat_vel, `OLFS_VLAT_OFS, `OLFS_VEL_SHIFT, `OLFS_VLAT_LEN),
        `OLFS_VLAT_START, `OLFS_VLAT_LEN),
        cvt({{24{p_rcs_q[15]}}, p_rcs_q}, `OLFS_RCS_OFS,
            `OLFS_RCS_SHIFT, `OLFS_RCS_LEN),
        `OLFS_RCS_START, `OLFS_RCS_LEN);

    olfs_obj_mem u_mem
    (
        .mclk(mclk),
        .wr_en(p_wr_q),
        .wr_addr(p_idx_q),
        .wr_data({p_ms_q, gen_word}),
        .rd_en(state_q == ST_RD),
        .rd_addr(idx_q),
        .rd_data(rd_data)
    );

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    assign object_count = (list_count > `OLFS_MAX_OBJECTS) ?
        `OLFS_MAX_OBJECTS : list_count;
    assign next_ph = next_phase(phase_q, enables_q);

    always @(posedge mclk)
    begin
        if (rst)
        begin
            cycle_counter_q <= 16'h0000;
        end
        else if (cycle_start)
        begin
            cycle_counter_q <= cycle_counter_q + 16'h0001;
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            phase_q <= PH_GEN;
            idx_q <= 7'h00;
            count_q <= 8'h00;
            enables_q <= 3'h0;
            frame_valid_q <= 1'b0;
            frame_ident_q <= 11'h000;
            frame_data_q <= 64'h0000000000000000;
            busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cycle_start && output_type_select == `OLFS_OUT_OBJECTS)
                    begin
                        count_q <= object_count;
                        enables_q <= {collision_detect_config,
                            extended_frames_enable, quality_frames_enable};
                        frame_ident_q <= `OLFS_ID_HEADER;
                        frame_data_q <= put(put(put(64'h0000000000000000,
                            {8'h00, object_count}, `OLFS_CNT_START, `OLFS_CNT_LEN),
                            cycle_counter_q, `OLFS_MEAS_START, `OLFS_MEAS_LEN),
                            {12'h000, `OLFS_FORMAT_VERSION},
                            `OLFS_VER_START, `OLFS_VER_LEN);
                        frame_valid_q <= 1'b1;
                        busy_q <= 1'b1;
                        state_q <= ST_HDR;
                    end
                end
                ST_HDR:
                begin
                    if (frame_ready)
                    begin
                        frame_valid_q <= 1'b0;
                        phase_q <= PH_GEN;
                        idx_q <= 7'h00;
                        if (count_q == 8'h00)
                        begin
                            busy_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            state_q <= ST_RD;
                        end
                    end
                end
                ST_RD:
                begin
                    state_q <= ST_LOAD;
                end
                ST_LOAD:
                begin
                    case (phase_q)
                        PH_GEN:
                        begin
                            frame_ident_q <= `OLFS_ID_GENERAL;
                            frame_data_q <= rd_data[63:0];
                        end
                        PH_QUAL:
                        begin
                            frame_ident_q <= `OLFS_ID_QUALITY;
                            frame_data_q <= put(put(64'h0000000000000000,
                                {8'h00, rd_data[7:0]}, `OLFS_TID_START, `OLFS_TID_LEN),
                                {13'h0000, rd_data[66:64]},
                                `OLFS_MST_START, `OLFS_MST_LEN);
                        end
                        PH_EXT:
                        begin
                            frame_ident_q <= `OLFS_ID_EXTENDED;
                            frame_data_q <= put(64'h0000000000000000,
                                {8'h00, rd_data[7:0]}, `OLFS_TID_START, `OLFS_TID_LEN);
                        end
                        default:
                        begin
                            frame_ident_q <= `OLFS_ID_WARNING;
                            frame_data_q <= put(64'h0000000000000000,
                                {8'h00, rd_data[7:0]}, `OLFS_TID_START, `OLFS_TID_LEN);
                        end
                    endcase
                    frame_valid_q <= 1'b1;
                    state_q <= ST_SEND;
                end
                ST_SEND:
                begin
                    if (frame_ready)
                    begin
                        frame_valid_q <= 1'b0;
                        if ({1'b0, idx_q} + 8'h01 < count_q)
                        begin
                            idx_q <= idx_q + 7'h01;
                            state_q <= ST_RD;
                        end
                        else if (next_ph == PH_DONE)
                        begin
                            busy_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            phase_q <= next_ph;
                            idx_q <= 7'h00;
                            state_q <= ST_RD;
                        end
                    end
                end
                default:
                begin
                    frame_valid_q <= 1'b0;
                    busy_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign frame_valid = frame_valid_q;
    assign frame_ident = frame_ident_q;
    assign frame_data = frame_data_q;
    assign busy = busy_q;
    assign wr_refused = wr_refused_q;
endmodule
`default_nettype wire

/* File: include/olfs_defs.vh */
// Constants of the object list frame sequencer: identifiers, field
// positions, conversion offsets and limits.
// Assumes inclusion by bare name from the design files.
`ifndef OLFS_DEFS_VH
`define OLFS_DEFS_VH
// Frame identifiers.
`define OLFS_ID_HEADER 11'h60A
`define OLFS_ID_GENERAL 11'h60B
`define OLFS_ID_QUALITY 11'h60C
`define OLFS_ID_EXTENDED 11'h60D
`define OLFS_ID_WARNING 11'h60E
// Output type code that selects the object list.
`define OLFS_OUT_OBJECTS 2'h1
`define OLFS_MAX_OBJECTS 8'h64
// Format revision; the value is arbitrary.
`define OLFS_FORMAT_VERSION 4'h1
// Header fields (start, length).
`define OLFS_CNT_START 0
`define OLFS_CNT_LEN 8
`define OLFS_MEAS_START 16
`define OLFS_MEAS_LEN 16
`define OLFS_VER_START 28
`define OLFS_VER_LEN 4
// Per-object fields (start, length).
`define OLFS_TID_START 0
`define OLFS_TID_LEN 8
`define OLFS_DLONG_START 19
`define OLFS_DLONG_LEN 13
`define OLFS_DLAT_START 24
`define OLFS_DLAT_LEN 11
`define OLFS_VLONG_START 46
`define OLFS_VLONG_LEN 10
`define OLFS_DYN_START 48
`define OLFS_DYN_LEN 3
`define OLFS_VLAT_START 53
`define OLFS_VLAT_LEN 9
`define OLFS_RCS_START 56
`define OLFS_RCS_LEN 8
`define OLFS_MST_START 50
`define OLFS_MST_LEN 3
// Offsets in input units and shifts that give one step of the field.
// Distances come in 0.1 m, velocities in 1/64 m/s, cross section in 0.25.
`define OLFS_DLONG_OFS -40'sd5000
`define OLFS_DLAT_OFS -40'sd2046
`define OLFS_VLONG_OFS -40'sd8192
`define OLFS_VLAT_OFS -40'sd4096
`define OLFS_RCS_OFS -40'sd256
`define OLFS_DIST_SHIFT 1
`define OLFS_VEL_SHIFT 4
`define OLFS_RCS_SHIFT 1
// Lever times yaw (0.1 m by 1/4096 rad/s) to 1/64 m/s.
`define OLFS_VY_SCALE 40'sd640
`define OLFS_COS_ONE_SHIFT 14
`endif

/* File: hw/olfs_obj_mem.v */
// Object record store: one word per tracked object slot.
// Assumes a single clock; read data appear one edge after rd_en.
`default_nettype none
module olfs_obj_mem
(
    input wire mclk,
    input wire wr_en,
    input wire [6:0] wr_addr,
    input wire [66:0] wr_data,
    input wire rd_en,
    input wire [6:0] rd_addr,
    output wire [66:0] rd_data
);
    reg [66:0] mem [0:99];
    reg [66:0] rd_data_q;

    always @(posedge mclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en)
        begin
            rd_data_q <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_q;
endmodule
`default_nettype wire

/* File: hw/olfs_vel_calc.v */
// Relative velocity components of one object, registered.
// Assumes sine and cosine of azimuth in 2.14 fixed point from outside.
`default_nettype none
`include "olfs_defs.vh"
module olfs_vel_calc
(
    input wire mclk,
    input wire rst,
    input wire signed [15:0] long_distance,
    input wire signed [15:0] radial_velocity,
    input wire signed [15:0] azimuth_sin,
    input wire signed [15:0] azimuth_cos,
    input wire signed [15:0] yaw_rate,
    input wire signed [15:0] rotation_lever,
    input wire obj_stationary,
    output wire signed [39:0] long_vel,
    output wire signed [39:0] lat_vel
);
    wire signed [39:0] lever_sum;
    wire signed [39:0] yaw_w;
    wire signed [39:0] vrad_w;
    wire signed [39:0] vrad_sh;
    wire signed [39:0] sin_w;
    wire signed [39:0] cos_w;
    wire signed [39:0] vy_st;
    wire signed [39:0] num_st;
    reg signed [39:0] long_vel_q;
    reg signed [39:0] lat_vel_q;

    assign lever_sum = {{24{long_distance[15]}}, long_distance}
        + {{24{rotation_lever[15]}}, rotation_lever};
    assign yaw_w = {{24{yaw_rate[15]}}, yaw_rate};
    assign vrad_w = {{24{radial_velocity[15]}}, radial_velocity};
    assign vrad_sh = vrad_w <<< `OLFS_COS_ONE_SHIFT;
    assign sin_w = {{24{azimuth_sin[15]}}, azimuth_sin};
    assign cos_w = {{24{azimuth_cos[15]}}, azimuth_cos};
    assign vy_st = -((lever_sum * yaw_w) / `OLFS_VY_SCALE);
    assign num_st = vrad_sh - sin_w * vy_st;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            long_vel_q <= 40'sh0000000000;
            lat_vel_q <= 40'sh0000000000;
        end
        else if (obj_stationary)
        begin
            lat_vel_q <= vy_st;
            long_vel_q <= (cos_w == 40'sh0000000000) ? vrad_w : num_st / cos_w;
        end
        else
        begin
            lat_vel_q <= 40'sh0000000000;
            long_vel_q <= (cos_w == 40'sh0000000000) ? vrad_w : vrad_sh / cos_w;
        end
    end

    assign long_vel = long_vel_q;
    assign lat_vel = lat_vel_q;
endmodule
`default_nettype wire

/* File: tb/olfs_sequencer_assertions.sv */
// Port checks of the object list frame sequencer.
// Assumes one clock mclk and a synchronous active-high rst.
`default_nettype none
`include "olfs_defs.vh"
module olfs_seq_checker
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] output_type_select,
    input wire logic cycle_start,
    input wire logic obj_wr,
    input wire logic [6:0] obj_wr_index,
    input wire logic frame_ready,
    input wire logic frame_valid,
    input wire logic [10:0] frame_ident,
    input wire logic [63:0] frame_data,
    input wire logic busy,
    input wire logic wr_refused
);
timeunit 1ns;
timeprecision 1ps;
logic [15:0] cnt_q;
wire hdr = frame_valid && frame_ident == `OLFS_ID_HEADER;
always @(posedge mclk)
    if (rst)
        cnt_q <= 16'h0;
    else if (cycle_start)
        cnt_q <= cnt_q + 16'h1;
default clocking cb @(posedge mclk);
endclocking
default disable iff (rst);
// ****************************************
// Assertions
// ****************************************
property p_start;
    cycle_start && !busy && output_type_select == `OLFS_OUT_OBJECTS |=> hdr && busy;
endproperty
a_start: assert property (p_start) else $error("no header after cycle start");
property p_off;
    !busy && output_type_select != `OLFS_OUT_OBJECTS |=> !frame_valid;
endproperty
a_off: assert property (p_off) else $error("frame without objects selected");
property p_first;
    $rose(busy) |-> hdr;
endproperty
a_first: assert property (p_first) else $error("list not opened by header");
property p_cnt;
    $rose(frame_valid) && hdr |-> {frame_data[15:8], frame_data[23:16]} == cnt_q - 16'h1;
endproperty
a_cnt: assert property (p_cnt) else $error("cycle counter wrong");
property p_max;
    hdr |-> frame_data[7:0] <= `OLFS_MAX_OBJECTS;
endproperty
a_max: assert property (p_max) else $error("object count above limit");
property p_ver;
    hdr |-> frame_data[31:28] == `OLFS_FORMAT_VERSION;
endproperty
a_ver: assert property (p_ver) else $error("format version wrong");
property p_hold;
    frame_valid && !frame_ready |=> frame_valid && $stable(frame_ident) && $stable(frame_data);
endproperty
a_hold: assert property (p_hold) else $error("frame changed before accept");
property p_gap;
    frame_valid && frame_ready |=> !frame_valid ##1 (!frame_valid || hdr);
endproperty
a_gap: assert property (p_gap) else $error("frame gap too short");
property p_ident;
    frame_valid |-> frame_ident >= `OLFS_ID_HEADER && frame_ident <= `OLFS_ID_WARNING;
endproperty
a_ident: assert property (p_ident) else $error("unknown frame identifier");
property p_refuse;
    obj_wr && (busy || obj_wr_index >= 7'h64) |=> wr_refused;
endproperty
a_refuse: assert property (p_refuse) else $error("bad write not refused");
endmodule
bind olfs_sequencer olfs_seq_checker u_chk
(
    .mclk, .rst, .output_type_select, .cycle_start, .obj_wr, .obj_wr_index,
    .frame_ready, .frame_valid, .frame_ident, .frame_data, .busy, .wr_refused
);
`default_nettype wire

/* File: tb/olfs_frame_sink.sv */
// Frame sink standing in for the controller that receives the list.
// Assumes one clock; when slow is high it stalls at random.
`default_nettype none
module olfs_frame_sink
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow,
    output logic frame_ready
);
timeunit 1ns;
timeprecision 1ps;
logic [31:0] r_q;
always @(posedge mclk)
    if (rst)
        r_q <= 32'h0000_0001;
    else
        r_q <= {r_q[30:0], r_q[31] ^ r_q[21] ^ r_q[1] ^ r_q[0]};
assign frame_ready = !slow || r_q[0];
endmodule
`default_nettype wire

/* File: tb/tb_olfs_sequencer.sv */
// Self-checking bench of the object list frame sequencer.
// Assumes the frame sink model and the bound port checker.
`default_nettype none
`include "olfs_defs.vh"
module tb_olfs_sequencer;
timeunit 1ns;
timeprecision 1ps;
logic mclk, rst, quality_frames_enable, extended_frames_enable, collision_detect_config;
logic cycle_start, obj_wr, obj_stationary, slow;
logic [1:0] output_type_select;
logic [7:0] list_count, track_identifier;
logic [6:0] obj_wr_index;
logic [2:0] dynamic_property, measurement_state;
logic signed [15:0] long_distance, lat_distance, radial_velocity, azimuth_sin, azimuth_cos;
logic signed [15:0] yaw_rate, rotation_lever, cross_section;
wire logic frame_ready, frame_valid, busy, wr_refused;
wire logic [10:0] frame_ident;
wire logic [63:0] frame_data;
logic [63:0] gx [100];
logic [7:0] ix [100];
logic [2:0] mx [100];
logic [74:0] got [$];
logic [74:0] exq [$];
logic [31:0] rs;
logic [15:0] mc;
int bad_count = 0;
int n_tests = 0;
olfs_sequencer u_dut
(
    .mclk, .rst, .output_type_select, .quality_frames_enable, .extended_frames_enable,
    .collision_detect_config, .cycle_start, .list_count, .obj_wr, .obj_wr_index,
    .track_identifier, .long_distance, .lat_distance, .radial_velocity, .azimuth_sin,
    .azimuth_cos, .yaw_rate, .rotation_lever, .obj_stationary, .dynamic_property,
    .cross_section, .measurement_state, .frame_ready, .frame_valid, .frame_ident,
    .frame_data, .busy, .wr_refused
);
olfs_frame_sink u_sink (.mclk, .rst, .slow, .frame_ready);
// ****************************************
// Reference functions and tasks
// ****************************************
function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
endfunction
function automatic logic [63:0] put(logic [63:0] w, longint v, int s, int n);
    int p;
    p = s;
    for (int i = 0; i < n; i++)
    begin
        w[p] = v[i];
        p = (p % 8 == 7) ? p - 15 : p + 1;
    end
    return w;
endfunction
function automatic longint cv(longint x, longint o, int s, int n);
    longint t;
    t = (x - o) >>> s;
    return t < 0 ? 0 : (t >= (1 << n) ? (1 << n) - 1 : t);
endfunction
task automatic chk(string nm, logic [74:0] s, logic [74:0] e);
    n_tests++;
    if (s !== e)
    begin
        bad_count++;
        $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
endtask
task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic wro(int i);
    logic [31:0] a, b, c;
    logic [63:0] e;
    longint x, r, s, k, w, l, vy, vx;
    logic st;
    @(posedge mclk);
    a = nx(rs);
    b = nx(a);
    c = nx(b);
    rs = nx(c);
    x = $signed(a[31:16]);
    r = $signed(b[31:16]);
    s = $signed(c[15:0]);
    k = (i < 2) ? 0 : 8192 + c[28:16];
    w = $signed(rs[15:0]);
    l = $signed(rs[31:16]);
    st = (i == 1) || ((i != 0) && c[29]);
    vy = st ? -((x + l) * w) / 640 : 0;
    vx = k == 0 ? r : (st ? (r * 16384 - s * vy) / k : r * 16384 / k);
    e = put(64'h0, a[7:0], 0, 8);
    e = put(e, cv(x, `OLFS_DLONG_OFS, 1, 13), 19, 13);
    e = put(e, cv($signed(b[15:0]), `OLFS_DLAT_OFS, 1, 11), 24, 11);
    e = put(e, cv(vx, `OLFS_VLONG_OFS, 4, 10), 46, 10);
    e = put(e, c[31:29], 48, 3);
    e = put(e, cv(vy, `OLFS_VLAT_OFS, 4, 9), 53, 9);
    e = put(e, cv($signed(a[15:0]), `OLFS_RCS_OFS, 1, 8), 56, 8);
    gx[i] = e;
    ix[i] = a[7:0];
    mx[i] = b[2:0];
    obj_wr <= 1'b1;
    obj_wr_index <= i[6:0];
    {track_identifier, cross_section, long_distance} <= {a[7:0], a[15:0], a[31:16]};
    {lat_distance, radial_velocity, measurement_state} <= {b[15:0], b[31:16], b[2:0]};
    {azimuth_sin, azimuth_cos, dynamic_property} <= {c[15:0], k[15:0], c[31:29]};
    {yaw_rate, rotation_lever, obj_stationary} <= {rs[15:0], rs[31:16], st};
endtask
task automatic bad(logic [6:0] i);
    @(posedge mclk);
    obj_wr <= 1'b1;
    obj_wr_index <= i;
    @(posedge mclk);
    obj_wr <= 1'b0;
    @(negedge mclk);
    chk("refused", wr_refused, 1'b1);
endtask
task automatic run(int n, logic [2:0] en, logic bz);
    int m, k;
    logic [3:0] f;
    @(posedge mclk);
    m = n > 100 ? 100 : n;
    f = (output_type_select == `OLFS_OUT_OBJECTS) ? {en, 1'b1} : 4'h0;
    if (f[0])
        exq.push_back({`OLFS_ID_HEADER, put(put(put(64'h0, m, 0, 8), mc, 16, 16),
            `OLFS_FORMAT_VERSION, 28, 4)});
    for (int t = 0; t < 4; t++)
        for (int i = 0; i < m; i++)
            if (f[t])
                exq.push_back({`OLFS_ID_GENERAL + t[10:0], t == 0 ? gx[i] :
                    put(put(64'h0, ix[i], 0, 8), t == 1 ? mx[i] : 3'h0, 50, 3)});
    mc++;
    list_count <= n[7:0];
    {collision_detect_config, extended_frames_enable, quality_frames_enable} <= en;
    cycle_start <= 1'b1;
    @(posedge mclk);
    cycle_start <= 1'b0;
    if (bz)
        bad(7'h05);
    @(negedge mclk);
    for (k = 0; k < 9000 && busy !== 1'b0; k++)
        @(negedge mclk);
    if (k == 9000)
    begin
        bad_count++;
        print_verdict();
    end
    chk("frame count", got.size(), exq.size());
    while (exq.size() > 0 && got.size() > 0)
        chk("frame", got.pop_front(), exq.pop_front());
    got.delete();
    exq.delete();
endtask
// ****************************************
// Stimulus
// ****************************************
initial
begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
always @(posedge mclk)
    if (frame_valid && frame_ready)
        got.push_back({frame_ident, frame_data});
initial
begin
    rst = 1'b1;
    {cycle_start, obj_wr, obj_stationary, slow, quality_frames_enable} = '0;
    {extended_frames_enable, collision_detect_config, list_count, track_identifier} = '0;
    {obj_wr_index, dynamic_property, measurement_state, long_distance, lat_distance} = '0;
    {radial_velocity, azimuth_sin, azimuth_cos, yaw_rate, rotation_lever} = '0;
    cross_section = '0;
    output_type_select = `OLFS_OUT_OBJECTS;
    rs = 32'hCF88E205;
    mc = 16'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 100; i++)
        wro(i);
    @(posedge mclk);
    obj_wr <= 1'b0;
    repeat (3) @(posedge mclk);
    for (int c = 0; c < 8; c++)
        run(1 + c, c[2:0], 1'b0);
    slow <= 1'b1;
    run(0, 3'h7, 1'b0);
    run(200, 3'h7, 1'b1);
    bad(7'h64);
    output_type_select <= 2'h0;
    run(3, 3'h1, 1'b0);
    output_type_select <= `OLFS_OUT_OBJECTS;
    run(3, 3'h1, 1'b0);
    print_verdict();
end
endmodule
`default_nettype wire
